// ===== common/spierr_map.svh
/*
 Timing counts and field positions for the serial error and interrupt block.
 Assumes inclusion by bare name from any design file that needs it.
*/
`ifndef SPIERR_MAP_SVH
`define SPIERR_MAP_SVH
// Bits in one serial byte
`define SPIERR_BITS 4'h8
// Bit count at which the bit 1 capture strobe falls (serial clock cycle 7)
`define SPIERR_OVR_BIT 4'h7
// Reset value of the transmit empty flag
`define SPIERR_TXE_RST 1'b1
`endif

// ===== common/spierr_pkg.sv
/*
 Types shared by the serial error and interrupt block.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package spierr_pkg;
   // Slave transfer tracker states, Gray coded from IDLE through XFER to DONE
   typedef enum logic [1:0] {
      SPIERR_IDLE = 2'b00,
      SPIERR_XFER = 2'b01,
      SPIERR_DONE = 2'b11
   } spierr_state_e;
   typedef logic [7:0] spierr_byte_t;
endpackage : spierr_pkg

// ===== hw/spierr_sync.sv
/*
 Two flip-flop level synchroniser.
 Assumes the input is a level from another clock domain or a pin.
*/
module spierr_sync (
   // Clock and reset
   input wire logic clk_i,
   input wire logic arst_n_i,
   // Level
   input wire logic d_i,
   output logic q_o
);
   logic meta_q;
   // Two stage capture
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         meta_q <= 1'b0;
         q_o <= 1'b0;
      end else begin
         meta_q <= d_i;
         q_o <= meta_q;
      end
   end
endmodule : spierr_sync

// ===== hw/spierr_link.sv
/*
 Link side of the slave path: counts serial clock edges on the link clock.
 Assumes the serial clock pin drives link_clk_i; select and phase are static
 during a byte. Publishes a toggle per finished byte and the bit count.
*/
module spierr_link
   import spierr_pkg::*;
(
   // Link clock and reset
   input wire logic link_clk_i,
   input wire logic arst_n_i,
   // Link pins
   input wire logic sel_n_i,
   input wire logic mosi_i,
   // Configuration
   input wire logic active_i,
   // Results
   output logic [3:0] bit_cnt_o,
   output logic byte_tgl_o,
   output spierr_pkg::spierr_byte_t rx_byte_o,
   output logic clk_seen_o
);
`include "spierr_map.svh"
   spierr_byte_t shift_q;
   wire logic capture = active_i && !sel_n_i;
   wire logic last_bit = bit_cnt_o == (`SPIERR_BITS - 4'h1);
   // Shift in while selected; select high ignores every edge
   always_ff @(posedge link_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         shift_q <= 8'h00;
         bit_cnt_o <= 4'h0;
         byte_tgl_o <= 1'b0;
         rx_byte_o <= 8'h00;
         clk_seen_o <= 1'b0;
      end else if (capture) begin
         shift_q <= {shift_q[6:0], mosi_i};
         clk_seen_o <= ~clk_seen_o;
         bit_cnt_o <= last_bit ? 4'h0 : bit_cnt_o + 4'h1;
         if (last_bit) begin
            rx_byte_o <= {shift_q[6:0], mosi_i};
            byte_tgl_o <= ~byte_tgl_o;
         end
      end
   end
endmodule : spierr_link

// ===== hw/spierr_core.sv
/*
 Error detection and interrupt request logic of a byte-wide serial interface.
 Assumes a CPU strobe interface on ref_clk_i, a slave link clocked by the
 serial clock pin, and that the shift engine reports master byte events.
*/
// Functional notes
// - Overrun sets when unread data remains at bit 1 capture strobe.
// - While overrun set, new bytes are dropped and full stays unchanged.
// - Overrun clears on status read followed by data read.
// - Full, mode fault and overrun share one receiver/error request.
// - One error enable gates both overrun and mode fault.
// - Master drives clock and MOSI; slave drives MISO.
// - Fault on slave deselect mid transfer or master select low.
// - Fault settable only with enable; disabling keeps existing flag.
// - Master fault clears enable, sets tx empty, clears counter, frees pins.
// - Phase-0 transfer starts at select fall; phase-1 at first clock.
// - Fault never changes master select; select ignored while disabled.
// - Phase-0 select pulse without clock faults; phase-1 does not.
// - Slave fault only flags and requests; module stays enabled.
// - Deselected slave floats MISO and ignores serial clock edges.
// - Fault clears on status read then control write, unless persisting.
// - Tx empty requests only with tx enable and module enable.
// - Rx full requests with rx enable regardless of module enable.
// - Full clears by status read then data read; empty by data write.
// - Full sets on byte into receive reg; empty on byte into shifter.
module spierr_core
   import spierr_pkg::*;
(
   // Clocks and reset
   input wire logic ref_clk_i,
   input wire logic link_clk_i,
   input wire logic arst_n_i,
   // CPU control bits
   input wire logic master_select_i,
   input wire logic clock_phase_i,
   input wire logic mode_fault_enable_i,
   input wire logic error_irq_enable_i,
   input wire logic tx_irq_enable_i,
   input wire logic rx_irq_enable_i,
   input wire logic module_enable_set_i,
   input wire logic module_enable_clr_i,
   // CPU access strobes
   input wire logic status_rd_i,
   input wire logic data_rd_i,
   input wire logic data_wr_i,
   input wire logic control_wr_i,
   input wire spierr_pkg::spierr_byte_t data_wr_val_i,
   // Master shift engine events
   input wire logic mst_bit1_strobe_i,
   input wire logic mst_byte_done_i,
   input wire spierr_pkg::spierr_byte_t mst_rx_byte_i,
   input wire logic tx_load_i,
   // Pins
   input wire logic sel_n_pin_i,
   input wire logic mosi_pin_i,
   output logic miso_oe_o,
   output logic mosi_oe_o,
   output logic sck_oe_o,
   // Status
   output logic module_enable_o,
   output logic receive_overrun_flag_o,
   output logic mode_fault_flag_o,
   output logic receive_full_flag_o,
   output logic transmit_empty_flag_o,
   output spierr_pkg::spierr_byte_t data_rd_val_o,
   output spierr_pkg::spierr_byte_t tx_data_o,
   output logic state_clr_o,
   // Interrupt requests
   output logic rx_err_irq_o,
   output logic tx_irq_o
);
`include "spierr_map.svh"
   // Registers
   logic ovr_q;
   logic mode_fault_flag_q;
   logic full_q;
   logic txe_q;
   logic en_q;
   logic ovr_armed_q;
   logic full_armed_q;
   logic mode_fault_flag_armed_q;
   logic tgl_seen_q;
   logic clk_seen_q;
   logic sel_prev_q;
   spierr_state_e st_q;
   spierr_state_e st_d;
   spierr_byte_t rx_q;
   spierr_byte_t tx_q;

   // Link side wires
   logic [3:0] lnk_cnt;
   logic lnk_tgl;
   logic lnk_clk_seen;
   spierr_byte_t lnk_byte;
   logic [3:0] cnt_s;
   logic tgl_s;
   logic clk_s;
   logic sel_n_s;
   logic [7:0] byte_s;

   // Select pin synchronised into the core domain
   spierr_sync u_sel_sync (
      .clk_i(ref_clk_i),
      .arst_n_i(arst_n_i),
      .d_i(sel_n_pin_i),
      .q_o(sel_n_s)
   );

   // Slave link logic on the serial clock
   spierr_link u_link (
      .link_clk_i(link_clk_i),
      .arst_n_i(arst_n_i),
      .sel_n_i(sel_n_pin_i),
      .mosi_i(mosi_pin_i),
      .active_i(en_q && !master_select_i),
      .bit_cnt_o(lnk_cnt),
      .byte_tgl_o(lnk_tgl),
      .rx_byte_o(lnk_byte),
      .clk_seen_o(lnk_clk_seen)
   );

   // Cross link results; byte held stable from toggle until next byte
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi = gi + 1) begin : g_cnt
         spierr_sync u_cnt (
            .clk_i(ref_clk_i),
            .arst_n_i(arst_n_i),
            .d_i(lnk_cnt[gi]),
            .q_o(cnt_s[gi])
         );
      end
      for (gi = 0; gi < 8; gi = gi + 1) begin : g_byte
         spierr_sync u_byte (
            .clk_i(ref_clk_i),
            .arst_n_i(arst_n_i),
            .d_i(lnk_byte[gi]),
            .q_o(byte_s[gi])
         );
      end
   endgenerate

   spierr_sync u_tgl_sync (
      .clk_i(ref_clk_i),
      .arst_n_i(arst_n_i),
      .d_i(lnk_tgl),
      .q_o(tgl_s)
   );

   spierr_sync u_clk_sync (
      .clk_i(ref_clk_i),
      .arst_n_i(arst_n_i),
      .d_i(lnk_clk_seen),
      .q_o(clk_s)
   );

   // Mode decode; master select only counts while enabled
   wire logic is_master = en_q && master_select_i;
   wire logic is_slave = en_q && !master_select_i;
   wire logic sel_fall = sel_prev_q && !sel_n_s;
   wire logic sel_rise = !sel_prev_q && sel_n_s;
   wire logic clk_edge = clk_s != clk_seen_q;

   // Slave byte and bit 1 strobe events
   wire logic slv_byte = is_slave && (tgl_s != tgl_seen_q);
   wire logic slv_bit1 = is_slave && clk_edge && (cnt_s == `SPIERR_OVR_BIT);
   wire logic bit1_strobe = (is_master && mst_bit1_strobe_i) || slv_bit1;
   wire logic byte_done = (is_master && mst_byte_done_i) || slv_byte;
   wire spierr_byte_t new_byte = is_master ? mst_rx_byte_i : byte_s;

   // Transfer tracking for the slave
   always_comb begin
      st_d = st_q;
      case (st_q)
         SPIERR_IDLE: begin
            if (is_slave && !clock_phase_i && sel_fall) begin
               st_d = SPIERR_XFER;
            end else if (is_slave && clock_phase_i && !sel_n_s && clk_edge) begin
               st_d = SPIERR_XFER;
            end
         end
         SPIERR_XFER: begin
            if (slv_byte) begin
               st_d = SPIERR_DONE;
            end else if (sel_rise) begin
               // Deselect ends a cut transfer; later select pulses start afresh
               st_d = SPIERR_IDLE;
            end
         end
         SPIERR_DONE: begin
            st_d = SPIERR_IDLE;
         end
         default: begin
            st_d = SPIERR_IDLE;
         end
      endcase
      if (!is_slave) begin
         st_d = SPIERR_IDLE;
      end
   end

   // Fault conditions
   wire logic slv_fault = is_slave && (st_q == SPIERR_XFER) && sel_rise;
   wire logic mst_fault = is_master && !sel_n_s;
   wire logic fault_now = mode_fault_enable_i && (slv_fault || mst_fault);
   wire logic mst_fault_ev = mode_fault_enable_i && mst_fault;

   // Clear sequences
   wire logic ovr_clr = ovr_armed_q && data_rd_i;
   wire logic full_clr = full_armed_q && data_rd_i;
   wire logic mode_fault_flag_clr = mode_fault_flag_armed_q && control_wr_i && !fault_now;
   wire logic ovr_set = bit1_strobe && full_q && !full_clr;
   wire logic rx_take = byte_done && !ovr_q && !ovr_set;

   // Core flags and arming
   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         ovr_q <= 1'b0;
         mode_fault_flag_q <= 1'b0;
         full_q <= 1'b0;
         ovr_armed_q <= 1'b0;
         full_armed_q <= 1'b0;
         mode_fault_flag_armed_q <= 1'b0;
         rx_q <= 8'h00;
      end else begin
         ovr_q <= ovr_set || (ovr_q && !ovr_clr);
         mode_fault_flag_q <= fault_now || (mode_fault_flag_q && !mode_fault_flag_clr);
         full_q <= rx_take || (full_q && !full_clr);
         if (rx_take) begin
            rx_q <= new_byte;
         end
         ovr_armed_q <= status_rd_i ? ovr_q : (ovr_armed_q && !data_rd_i && ovr_q);
         full_armed_q <= status_rd_i ? full_q : (full_armed_q && !data_rd_i && full_q);
         mode_fault_flag_armed_q <= status_rd_i ? mode_fault_flag_q :
            (mode_fault_flag_armed_q && !control_wr_i && !fault_now && mode_fault_flag_q);
      end
   end

   // Module enable, transmit empty and transmit holding register
   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         en_q <= 1'b0;
         txe_q <= `SPIERR_TXE_RST;
         tx_q <= 8'h00;
      end else begin
         if (mst_fault_ev || module_enable_clr_i) begin
            en_q <= 1'b0;
         end else if (module_enable_set_i) begin
            en_q <= 1'b1;
         end
         if (mst_fault_ev || !en_q || tx_load_i) begin
            txe_q <= 1'b1;
         end else if (data_wr_i) begin
            txe_q <= 1'b0;
         end
         if (data_wr_i) begin
            tx_q <= data_wr_val_i;
         end
      end
   end

   // Tracker, edge history and outputs
   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         st_q <= SPIERR_IDLE;
         tgl_seen_q <= 1'b0;
         clk_seen_q <= 1'b0;
         sel_prev_q <= 1'b1;
         miso_oe_o <= 1'b0;
         mosi_oe_o <= 1'b0;
         sck_oe_o <= 1'b0;
         state_clr_o <= 1'b1;
         rx_err_irq_o <= 1'b0;
         tx_irq_o <= 1'b0;
      end else begin
         st_q <= st_d;
         tgl_seen_q <= tgl_s;
         clk_seen_q <= clk_s;
         sel_prev_q <= sel_n_s;
         // Pin directions; master fault returns pins to the port
         mosi_oe_o <= is_master && !mst_fault_ev;
         sck_oe_o <= is_master && !mst_fault_ev;
         miso_oe_o <= is_slave && !sel_n_s;
         state_clr_o <= mst_fault_ev || !en_q;
         rx_err_irq_o <= (rx_irq_enable_i && full_q) ||
            (error_irq_enable_i && (ovr_q || mode_fault_flag_q));
         tx_irq_o <= tx_irq_enable_i && en_q && txe_q;
      end
   end

   // Flag outputs come straight from their registers
   assign module_enable_o = en_q;
   assign receive_overrun_flag_o = ovr_q;
   assign mode_fault_flag_o = mode_fault_flag_q;
   assign receive_full_flag_o = full_q;
   assign transmit_empty_flag_o = txe_q;
   assign data_rd_val_o = rx_q;
   assign tx_data_o = tx_q;
endmodule : spierr_core

// ===== dv/spierr_props.sv
/*
 Checker for the serial error and interrupt block, bound into spierr_core.
 Assumes the core's port names and the single ref_clk_i domain.
*/
module spierr_props
   import spierr_pkg::*;
(
   // Clock, reset and controls
   input wire logic ref_clk_i, arst_n_i, master_select_i, mode_fault_enable_i,
   input wire logic error_irq_enable_i, tx_irq_enable_i, rx_irq_enable_i,
   input wire logic module_enable_clr_i, status_rd_i, data_rd_i, data_wr_i,
   input wire logic control_wr_i, tx_load_i, sel_n_pin_i,
   // Observed outputs
   input wire logic miso_oe_o, mosi_oe_o, sck_oe_o, module_enable_o, state_clr_o,
   input wire logic receive_overrun_flag_o, mode_fault_flag_o, receive_full_flag_o,
   input wire logic transmit_empty_flag_o, rx_err_irq_o, tx_irq_o,
   input wire spierr_pkg::spierr_byte_t data_rd_val_o
);
   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (!arst_n_i);
   // Request gating terms
   wire tx_off = !tx_irq_enable_i || !module_enable_o;
   wire rx_on = rx_irq_enable_i && receive_full_flag_o;
   wire er_on = error_irq_enable_i && (mode_fault_flag_o || receive_overrun_flag_o);
   wire all_off = !rx_irq_enable_i && !error_irq_enable_i;
   a_tx_gate: assert property (tx_off && $past(tx_off) |-> !tx_irq_o)
      else $error("tx request while gated");
   a_rx_request: assert property (rx_on && $past(rx_on) |-> rx_err_irq_o)
      else $error("rx request missing");
   a_err_request: assert property (er_on && $past(er_on) |-> rx_err_irq_o)
      else $error("error request missing");
   a_err_gate: assert property (all_off && $past(all_off) |-> !rx_err_irq_o)
      else $error("rx error request while disabled");
   a_master_fault: assert property ($fell(module_enable_o) && !$past(module_enable_clr_i)
      |-> mode_fault_flag_o && transmit_empty_flag_o && state_clr_o)
      else $error("enable dropped without fault effects");
   a_fault_enable: assert property ($rose(mode_fault_flag_o) |-> $past(mode_fault_enable_i))
      else $error("mode fault set while disabled");
   a_ovr_freeze: assert property (receive_overrun_flag_o && $past(receive_overrun_flag_o)
      |-> !$rose(receive_full_flag_o) && $stable(data_rd_val_o))
      else $error("receive data moved during overrun");
   a_ovr_clear: assert property (receive_overrun_flag_o && status_rd_i ##1 data_rd_i
      |=> !receive_overrun_flag_o)
      else $error("overrun not cleared");
   a_fault_clear: assert property ((sel_n_pin_i && master_select_i) [*4]
      ##0 (mode_fault_flag_o && status_rd_i) ##1 (control_wr_i && sel_n_pin_i)
      |=> !mode_fault_flag_o) else $error("mode fault not cleared");
   a_txe_write: assert property (data_wr_i && module_enable_o && !tx_load_i
      |=> !transmit_empty_flag_o) else $error("tx empty not cleared");
   a_master_pins: assert property ((module_enable_o && master_select_i) [*3]
      |-> sck_oe_o && mosi_oe_o && !miso_oe_o) else $error("master pin directions");
   a_miso_float: assert property (sel_n_pin_i [*4] |-> !miso_oe_o)
      else $error("miso driven while deselected");
   // Main scenarios reached
   c_overrun: cover property ($rose(receive_overrun_flag_o));
   c_mfault: cover property ($rose(mode_fault_flag_o) && master_select_i);
   c_txirq: cover property ($rose(tx_irq_o));
endmodule : spierr_props
bind spierr_core spierr_props u_props (.*);

// ===== dv/spierr_remote_master.sv
/*
 Remote serial master model driving the slave link pins.
 Assumes an idle-low serial clock of 48 ns period, MSB first.
*/
module spierr_remote_master (
   // Link pins
   output logic sck_o,
   output logic sel_n_o,
   output logic mosi_o
);
   timeunit 1ns;
   timeprecision 100ps;
   // Idle link, clock standing still
   initial begin
      sck_o = 1'h0;
      sel_n_o = 1'h1;
      mosi_o = 1'h0;
   end
   // Select, clock out n bits, deselect unless kept
   task automatic frame(input logic [7:0] b, input int n, input logic keep);
      sel_n_o = 1'h0;
      #24;
      for (int i = 0; i < n; i++) begin
         mosi_o = b[7 - i];
         #24 sck_o = 1'h1;
         #24 sck_o = 1'h0;
      end
      #24;
      mosi_o = ~mosi_o; // Released line shows no stale bit
      sel_n_o = keep ? 1'h0 : 1'h1;
      #24;
   endtask : frame
endmodule : spierr_remote_master

// ===== dv/spierr_core_tb_top.sv
/*
 Self-checking bench for the serial error and interrupt block.
 Assumes the remote master model and the bound checker are compiled.
*/
module spierr_core_tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   logic ref_clk_i = 1'h0;
   logic arst_n_i = 1'h0;
   logic msel = 1'h0, clock_phase = 1'h0, mfe = 1'h0, erie = 1'h0, txie = 1'h0, rxie = 1'h0;
   logic [8:0] stb = 9'h000;
   logic [7:0] wval = 8'h00, mbyte = 8'h00;
   wire sck, sel_n, mosi, miso_oe, mosi_oe, sck_oe, me, ovr, mf, full, txe, sclr, rxi, txi;
   wire [7:0] rdv, txd;
   wire [7:0] fl = {sclr, txi, rxi, me, txe, full, mf, ovr};
   wire [7:0] oe = {5'h00, sck_oe, mosi_oe, miso_oe};
   int n_errors = 0, checked = 0, cyc = 0;
   always #5 ref_clk_i = ~ref_clk_i;
   spierr_remote_master mdl (.sck_o(sck), .sel_n_o(sel_n), .mosi_o(mosi));
   spierr_core dut (
      .ref_clk_i(ref_clk_i), .link_clk_i(sck), .arst_n_i(arst_n_i),
      .master_select_i(msel), .clock_phase_i(clock_phase), .mode_fault_enable_i(mfe),
      .error_irq_enable_i(erie), .tx_irq_enable_i(txie), .rx_irq_enable_i(rxie),
      .module_enable_set_i(stb[7]), .module_enable_clr_i(stb[8]), .status_rd_i(stb[0]),
      .data_rd_i(stb[1]), .data_wr_i(stb[2]), .control_wr_i(stb[3]), .data_wr_val_i(wval),
      .mst_bit1_strobe_i(stb[4]), .mst_byte_done_i(stb[5]), .mst_rx_byte_i(mbyte),
      .tx_load_i(stb[6]), .sel_n_pin_i(sel_n), .mosi_pin_i(mosi), .miso_oe_o(miso_oe),
      .mosi_oe_o(mosi_oe), .sck_oe_o(sck_oe), .module_enable_o(me),
      .receive_overrun_flag_o(ovr), .mode_fault_flag_o(mf), .receive_full_flag_o(full),
      .transmit_empty_flag_o(txe), .data_rd_val_o(rdv), .tx_data_o(txd),
      .state_clr_o(sclr), .rx_err_irq_o(rxi), .tx_irq_o(txi));
   task automatic tick();
      @(posedge ref_clk_i);
      #1;
   endtask : tick
   // Two strobe cycles, then an idle one
   task automatic pulse2(input logic [8:0] a, input logic [8:0] b);
      stb = a;
      tick();
      stb = b;
      tick();
      stb = 9'h000;
      tick();
   endtask : pulse2
   // Bounded wait for one flag bit
   task automatic waitf(input int b);
      tick();
      for (int i = 0; i < 30 && fl[b] !== 1'h1; i++) tick();
      tick();
   endtask : waitf
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      checked++;
      if (g !== e) begin
         n_errors++;
         $display("mismatch %s exp %h got %h", nm, e, g);
      end
   endtask : chk
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : wrap_up
   // Slave byte, receive request with module on and off, flag clear
   task automatic t_rx();
      rxie = 1'h1;
      pulse2(9'h080, 9'h000);
      mdl.frame(8'ha5, 8, 1'h0);
      waitf(2);
      chk("rx flags", 8'h3c, fl);
      chk("rx data", 8'ha5, rdv);
      pulse2(9'h100, 9'h000);
      chk("rx off", 8'hac, fl);
      pulse2(9'h001, 9'h002);
      chk("rx clear", 8'h88, fl);
      pulse2(9'h080, 9'h000);
      rxie = 1'h0;
      $display("test rx done");
   endtask : t_rx
   // Unread byte overrun, error enable, clear and status reread
   task automatic t_ovr();
      mdl.frame(8'h11, 8, 1'h0);
      waitf(2);
      mdl.frame(8'h22, 8, 1'h0);
      waitf(0);
      chk("ovr flags", 8'h1d, fl);
      chk("ovr data", 8'h11, rdv);
      erie = 1'h1;
      waitf(5);
      chk("ovr irq", 8'h3d, fl);
      pulse2(9'h001, 9'h002);
      pulse2(9'h001, 9'h000);
      chk("ovr clear", 8'h18, fl);
      $display("test overrun done");
   endtask : t_ovr
   // Slave faults in both phases, enable gating and clearing
   task automatic t_sf();
      mfe = 1'h1;
      mdl.frame(8'h00, 0, 1'h0);
      waitf(1);
      chk("ph0 pulse", 8'h3a, fl);
      pulse2(9'h001, 9'h008);
      chk("mf clear", 8'h18, fl);
      clock_phase = 1'h1;
      mdl.frame(8'h00, 0, 1'h0);
      repeat (6) tick();
      chk("ph1 pulse", 8'h18, fl);
      mdl.frame(8'h00, 4, 1'h0);
      waitf(1);
      mfe = 1'h0;
      tick();
      chk("ph1 cut", 8'h3a, fl);
      pulse2(9'h001, 9'h008);
      clock_phase = 1'h0;
      mdl.frame(8'h00, 0, 1'h0);
      repeat (6) tick();
      chk("mf blocked", 8'h18, fl);
      $display("test slave fault done");
   endtask : t_sf
   // Transmit flag, master pins, master fault and recovery
   task automatic t_mf();
      msel = 1'h1;
      mfe = 1'h1;
      txie = 1'h1;
      wval = 8'h5a;
      pulse2(9'h004, 9'h000);
      chk("tx written", 8'h10, fl);
      chk("tx data", 8'h5a, txd);
      pulse2(9'h040, 9'h000);
      chk("tx loaded", 8'h58, fl);
      chk("pins", 8'h06, oe);
      pulse2(9'h004, 9'h000);
      mdl.frame(8'h00, 0, 1'h1);
      waitf(1);
      chk("fault", 8'haa, fl);
      chk("pins off", 8'h00, oe);
      mdl.frame(8'h00, 0, 1'h0);
      repeat (6) tick();
      pulse2(9'h001, 9'h008);
      chk("mf clear", 8'h88, fl);
      $display("test master fault done");
   endtask : t_mf
   // Master byte events and master overrun
   task automatic t_mb();
      pulse2(9'h080, 9'h000);
      mbyte = 8'h3c;
      pulse2(9'h020, 9'h010);
      chk("mst ovr", 8'h7d, fl);
      chk("mst data", 8'h3c, rdv);
      pulse2(9'h001, 9'h002);
      chk("mst clear", 8'h58, fl);
      $display("test master byte done");
   endtask : t_mb
   // Run limit
   always @(posedge ref_clk_i) begin
      cyc++;
      if (cyc == 4000) begin
         n_errors++;
         wrap_up();
      end
   end
   initial begin
      repeat (3) @(posedge ref_clk_i);
      #1 arst_n_i = 1'h1;
      tick();
      chk("reset", 8'h88, fl);
      t_rx();
      t_ovr();
      t_sf();
      t_mf();
      t_mb();
      wrap_up();
   end
endmodule : spierr_core_tb_top
